/* tpw_map.vh */
// register map, field positions, reset values and fixed counts of the pwm timer core
`ifndef TPW_MAP_VH
`define TPW_MAP_VH

// register indices on the plain register port
`define TPW_A_CTRL     4'h0
`define TPW_A_PRESC    4'h1
`define TPW_A_PERIOD   4'h2
`define TPW_A_INIT     4'h3
`define TPW_A_CMP1     4'h4
`define TPW_A_CMP2     4'h5
`define TPW_A_CMP3     4'h6
`define TPW_A_CMP4     4'h7
`define TPW_A_MODE     4'h8
`define TPW_A_OSC      4'h9
`define TPW_A_FLAG_EN  4'ha
`define TPW_A_COUNT    4'hb
`define TPW_A_STATE    4'hc

// timer_control_word fields
`define TPW_CTRL_CEN    0
`define TPW_CTRL_UPDATE_DISABLE   1
`define TPW_CTRL_DIR    4
`define TPW_CTRL_CMS_LO 5
`define TPW_CTRL_CMS_HI 6
`define TPW_CTRL_PERIOD_PRELOAD_ENABLE   7
`define TPW_CTRL_IDIR   12
`define TPW_CTRL_RST    16'h0081

// center_mode_select codes
`define TPW_CMS_EDGE    2'h0
`define TPW_CMS_DOWN    2'h1
`define TPW_CMS_UP      2'h2

// reference_mode_field codes
`define TPW_OM_FROZEN   3'h0
`define TPW_OM_SET      3'h1
`define TPW_OM_CLR      3'h2
`define TPW_OM_TOGGLE   3'h3
`define TPW_OM_LOW      3'h4
`define TPW_OM_HIGH     3'h5
`define TPW_OM_PWM1     3'h6
`define TPW_OM_PWM2     3'h7

// flag_enable_register and output_stage_config layout
`define TPW_FE_UPD      0
`define TPW_FE_CH0      1
`define TPW_OSC_STRIDE  4
`define TPW_OSC_EN      0
`define TPW_OSC_POL     1

// channels present in this variant
`define TPW_NUM_CH      4
`define TPW_MAX_CH      4

// reset values
`define TPW_RST_PERIOD  16'hffff
`define TPW_RST_ZERO    16'h0000

`endif

/* tpw_presc.v */
// prescaler producing the one-cycle counter_tick
`timescale 1ns/1ps
module tpw_presc (
  input  wire        clk,
  input  wire        rst,
  input  wire        run,
  input  wire [15:0] prescale_divider,
  output reg         tick_q
);

  reg [15:0] div_q;

  // tick period is (prescale_divider + 1) input clocks
  always @(posedge clk) begin
    if (rst) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (!run) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q >= prescale_divider) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

endmodule // tpw_presc

/* tpw_chan.v */
// one channel of the output mode controller
`timescale 1ns/1ps
`include "tpw_map.vh"
module tpw_chan (
  input  wire       clk,
  input  wire       rst,
  input  wire [2:0] mode,
  input  wire       match,
  input  wire       below,
  output reg        ref_q
);

  reg ref_d;

  always @* begin
    ref_d = ref_q;
    case (mode)
      `TPW_OM_FROZEN: ref_d = ref_q;
      `TPW_OM_SET:    if (match) ref_d = 1'b1;
      `TPW_OM_CLR:    if (match) ref_d = 1'b0;
      `TPW_OM_TOGGLE: if (match) ref_d = ~ref_q;
      `TPW_OM_LOW:    ref_d = 1'b0;
      `TPW_OM_HIGH:   ref_d = 1'b1;
      `TPW_OM_PWM1:   ref_d = below;
      `TPW_OM_PWM2:   ref_d = ~below;
      default:        ref_d = ref_q;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
    end
  end

endmodule // tpw_chan

/* tpw_core.v */
// pwm timer core: register port, counter, preload, flags and channel outputs
`timescale 1ns/1ps
`include "tpw_map.vh"
module tpw_core (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_we,
  input  wire        reg_re,
  output reg  [15:0] reg_rdata_q,
  input  wire        counter_realign,
  output reg  [3:0]  pwm_out_q,
  output reg  [3:0]  channel_match_flag_q,
  output reg         update_flag_q
);

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  reg  [15:0] timer_control_word_q;
  reg  [15:0] prescale_divider_q;
  reg  [15:0] period_input_q;
  reg  [15:0] init_count_q;
  reg  [63:0] compare_input_q;
  reg  [11:0] mode_input_q;
  reg  [15:0] output_stage_config_q;
  reg  [15:0] flag_enable_register_q;

  // ---------------------------------------------------------------
  // active (preloaded) configuration and counter state
  // ---------------------------------------------------------------
  reg  [15:0] period_value_q;
  reg  [63:0] compare_value_q;
  reg  [11:0] reference_mode_q;
  reg  [15:0] count_q;
  reg  [15:0] count_d;
  reg         down_q;
  reg         down_d;
  reg         update_event;
  reg         realign_q;
  reg         tick_seen_q;
  reg         init_load_q;

  wire        counter_enable;
  wire        update_disable;
  wire        count_direction;
  wire [1:0]  center_mode_select;
  wire        init_direction;
  wire        center;
  wire        tick;
  wire        realign_edge;
  wire [3:0]  reference;
  wire [3:0]  match;
  wire [3:0]  below;
  wire [3:0]  ch_present;
  wire        dir_ok;

  assign counter_enable     = timer_control_word_q[`TPW_CTRL_CEN];
  assign update_disable     = timer_control_word_q[`TPW_CTRL_UPDATE_DISABLE];
  assign count_direction    = timer_control_word_q[`TPW_CTRL_DIR];
  assign center_mode_select = timer_control_word_q[`TPW_CTRL_CMS_HI:`TPW_CTRL_CMS_LO];
  assign init_direction     = timer_control_word_q[`TPW_CTRL_IDIR];
  assign center             = (center_mode_select != `TPW_CMS_EDGE);

  // realign is a pin taken as synchronous; only its rising edge acts
  assign realign_edge = counter_realign & ~realign_q;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // period, compare and mode words written here are only pending values;
  // the counter sees them at the next update event. the output stage word
  // is used directly, so a write changes the pins two cycles after the strobe.
  always @(posedge clk) begin
    if (rst) begin
      timer_control_word_q   <= `TPW_CTRL_RST;
      prescale_divider_q     <= `TPW_RST_ZERO;
      period_input_q         <= `TPW_RST_PERIOD;
      init_count_q           <= `TPW_RST_ZERO;
      compare_input_q        <= 64'h0000000000000000;
      mode_input_q           <= 12'h000;
      output_stage_config_q  <= `TPW_RST_ZERO;
      flag_enable_register_q <= `TPW_RST_ZERO;
      init_load_q            <= 1'b0;
    end else begin
      init_load_q <= 1'b0;
      if (reg_we) begin
        case (reg_addr)
          `TPW_A_CTRL:    timer_control_word_q   <= reg_wdata;
          `TPW_A_PRESC:   prescale_divider_q     <= reg_wdata;
          `TPW_A_PERIOD:  period_input_q         <= reg_wdata;
          `TPW_A_INIT: begin
            init_count_q <= reg_wdata;
            init_load_q  <= 1'b1;
          end
          `TPW_A_CMP1:    compare_input_q[15:0]  <= reg_wdata;
          `TPW_A_CMP2:    compare_input_q[31:16] <= reg_wdata;
          `TPW_A_CMP3:    compare_input_q[47:32] <= reg_wdata;
          `TPW_A_CMP4:    compare_input_q[63:48] <= reg_wdata;
          `TPW_A_MODE:    mode_input_q           <= reg_wdata[11:0];
          `TPW_A_OSC:     output_stage_config_q  <= reg_wdata;
          `TPW_A_FLAG_EN: flag_enable_register_q <= reg_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_re) begin
      case (reg_addr)
        `TPW_A_CTRL:    reg_rdata_q <= timer_control_word_q;
        `TPW_A_PRESC:   reg_rdata_q <= prescale_divider_q;
        `TPW_A_PERIOD:  reg_rdata_q <= period_input_q;
        `TPW_A_INIT:    reg_rdata_q <= init_count_q;
        `TPW_A_CMP1:    reg_rdata_q <= compare_input_q[15:0];
        `TPW_A_CMP2:    reg_rdata_q <= compare_input_q[31:16];
        `TPW_A_CMP3:    reg_rdata_q <= compare_input_q[47:32];
        `TPW_A_CMP4:    reg_rdata_q <= compare_input_q[63:48];
        `TPW_A_MODE:    reg_rdata_q <= {4'h0, mode_input_q};
        `TPW_A_OSC:     reg_rdata_q <= output_stage_config_q;
        `TPW_A_FLAG_EN: reg_rdata_q <= flag_enable_register_q;
        `TPW_A_COUNT:   reg_rdata_q <= count_q;
        `TPW_A_STATE:   reg_rdata_q <= {11'h000, down_q, reference};
        default:        reg_rdata_q <= 16'h0000;
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  // counting stops with counter_enable low; software is expected to keep it set
  tpw_presc u_presc (
    .clk              (clk),
    .rst              (rst),
    .run              (counter_enable),
    .prescale_divider (prescale_divider_q),
    .tick_q           (tick)
  );

  // ---------------------------------------------------------------
  // counter next state
  // ---------------------------------------------------------------
  always @* begin
    count_d      = count_q;
    down_d       = down_q;
    update_event = 1'b0;
    if (tick) begin
      if (!center) begin
        down_d = count_direction;
        if (!count_direction) begin
          if (count_q >= period_value_q) begin
            count_d      = 16'h0000;
            update_event = 1'b1;
          end else begin
            count_d = count_q + 16'h0001;
          end
        end else begin
          if (count_q == 16'h0000 || count_q > period_value_q) begin
            // reload with the period that this same event makes active, so a
            // shorter period never leaves the count above its new top
            count_d      = update_disable ? period_value_q : period_input_q;
            update_event = 1'b1;
          end else begin
            count_d = count_q - 16'h0001;
          end
        end
      end else if (period_value_q == 16'h0000) begin
        // a zero period parks the counter; no turning points exist
        count_d = 16'h0000;
      end else if (!down_q) begin
        if (count_q >= period_value_q) begin
          count_d      = period_value_q - 16'h0001;
          down_d       = 1'b1;
          update_event = 1'b1;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end else begin
        if (count_q == 16'h0000) begin
          count_d      = 16'h0001;
          down_d       = 1'b0;
          update_event = 1'b1;
        end else if (count_q > period_value_q) begin
          count_d = period_value_q;
        end else begin
          count_d = count_q - 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // counter and preload registers
  // ---------------------------------------------------------------
  // the preload path is always used; the period_preload_enable bit is kept
  // only so software can read back what it wrote
  always @(posedge clk) begin
    if (rst) begin
      count_q          <= 16'h0000;
      down_q           <= 1'b0;
      realign_q        <= 1'b0;
      period_value_q   <= `TPW_RST_PERIOD;
      compare_value_q  <= 64'h0000000000000000;
      reference_mode_q <= 12'h000;
    end else begin
      realign_q <= counter_realign;
      if (realign_edge) begin
        count_q          <= 16'h0000;
        // a center counter restarted at zero can only head up; otherwise the
        // first tick would turn at once and raise a spurious update
        down_q           <= center ? 1'b0 : count_direction;
        period_value_q   <= period_input_q;
        compare_value_q  <= compare_input_q;
        reference_mode_q <= mode_input_q;
      end else if (init_load_q) begin
        count_q <= init_count_q;
        down_q  <= center ? init_direction : count_direction;
      end else begin
        count_q <= count_d;
        down_q  <= down_d;
        if (update_event && !update_disable) begin
          period_value_q   <= period_input_q;
          compare_value_q  <= compare_input_q;
          reference_mode_q <= mode_input_q;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // compare, flags and output mode controller
  // ---------------------------------------------------------------
  // matches are judged one cycle after the tick, on the settled count
  always @(posedge clk) begin
    if (rst) begin
      tick_seen_q <= 1'b0;
    end else begin
      // a loaded or realigned count was not reached by counting, so no
      // match is judged on it
      tick_seen_q <= tick & ~realign_edge & ~init_load_q;
    end
  end

  // down and up center modes flag only in their own direction; center mode 3 flags in both
  assign dir_ok = (center_mode_select == `TPW_CMS_DOWN) ? down_q :
                  (center_mode_select == `TPW_CMS_UP)   ? ~down_q : 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < `TPW_MAX_CH; gi = gi + 1) begin : g_ch
      assign ch_present[gi] = (gi < `TPW_NUM_CH);
      assign match[gi] = tick_seen_q & (count_q == compare_value_q[gi*16 +: 16]);
      assign below[gi] = (count_q < compare_value_q[gi*16 +: 16]);

      // capture and one-shot do not exist; every channel is an output
      tpw_chan u_chan (
        .clk   (clk),
        .rst   (rst),
        .mode  (reference_mode_q[gi*3 +: 3]),
        .match (match[gi]),
        .below (below[gi]),
        .ref_q (reference[gi])
      );
    end
  endgenerate

  // flags are one-cycle pulses; nothing here is sticky
  always @(posedge clk) begin
    if (rst) begin
      channel_match_flag_q <= 4'h0;
      update_flag_q        <= 1'b0;
    end else begin
      channel_match_flag_q <= match & {4{dir_ok}} & ch_present
                              & flag_enable_register_q[`TPW_FE_CH0 +: 4];
      update_flag_q        <= update_event & ~update_disable & ~realign_edge & ~init_load_q
                              & flag_enable_register_q[`TPW_FE_UPD];
    end
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  // main outputs are assumed on; a disabled channel drives low
  integer k;
  reg [3:0] pwm_out_d;
  always @* begin
    pwm_out_d = 4'h0;
    for (k = 0; k < `TPW_MAX_CH; k = k + 1) begin
      if (output_stage_config_q[k*`TPW_OSC_STRIDE + `TPW_OSC_EN]) begin
        pwm_out_d[k] = reference[k] ^ output_stage_config_q[k*`TPW_OSC_STRIDE + `TPW_OSC_POL];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pwm_out_q <= 4'h0;
    end else begin
      pwm_out_q <= pwm_out_d;
    end
  end

endmodule // tpw_core

/* tpw_core_chk.sv */
// port-level assertion checker for the pwm timer core
`timescale 1ns/1ps
module tpw_core_chk (
  input wire        clk,
  input wire        rst,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_we,
  input wire        reg_re,
  input wire [15:0] reg_rdata_q,
  input wire        counter_realign,
  input wire [3:0]  pwm_out_q,
  input wire [3:0]  channel_match_flag_q,
  input wire        update_flag_q
);
  // ----------
  // shadows of the writes that gate outputs, and of the prescaler write
  // ----------
  logic [15:0] fe_q;
  logic [15:0] ps_q;
  logic [15:0] osc_q;
  wire  [3:0]  oe = {osc_q[12], osc_q[8], osc_q[4], osc_q[0]};
  wire  [3:0]  ce = fe_q[4:1];
  always @(posedge clk) begin
    if (rst) begin
      fe_q  <= 16'h0000;
      ps_q  <= 16'h0000;
      osc_q <= 16'h0000;
    end else if (reg_we) begin
      if (reg_addr == 4'ha) fe_q <= reg_wdata;
      if (reg_addr == 4'h1) ps_q <= reg_wdata;
      if (reg_addr == 4'h9) osc_q <= reg_wdata;
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property (reg_re && reg_addr > 4'hc |=> reg_rdata_q == 16'h0000)
    else $error("unmapped read not zero");
  a_upd_gated: assert property (update_flag_q |-> fe_q[0] || $past(fe_q[0]))
    else $error("update flag while disabled");
  a_match_gated: assert property ((channel_match_flag_q & ~(ce | $past(ce) | $past(ce, 2))) == 4'h0)
    else $error("match flag while disabled");
  a_upd_pulse: assert property (update_flag_q && ps_q != 16'h0000 && $past(ps_q) != 16'h0000 |=> !update_flag_q)
    else $error("update flag longer than one clock");
  a_match_pulse: assert property (channel_match_flag_q != 4'h0 && ps_q != 16'h0000 |=> (channel_match_flag_q & $past(channel_match_flag_q)) == 4'h0)
    else $error("match flag longer than one clock");
  a_out_enable: assert property ((pwm_out_q & ~(oe | $past(oe) | $past(oe, 2))) == 4'h0)
    else $error("disabled output driven");
  a_osc_now: assert property (reg_we && reg_addr == 4'h9 && reg_wdata == 16'h0000 |-> ##2 pwm_out_q == 4'h0)
    else $error("output stage change not immediate");
  a_realign_quiet: assert property ($rose(counter_realign) |=> !update_flag_q)
    else $error("update flag on realign");
endmodule // tpw_core_chk

bind tpw_core tpw_core_chk i_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .counter_realign(counter_realign),
  .pwm_out_q(pwm_out_q), .channel_match_flag_q(channel_match_flag_q), .update_flag_q(update_flag_q)
);

/* tpw_gate_model.sv */
// gate driver side model: on-time counter for each pwm line
`timescale 1ns/1ps
module tpw_gate_model (
  input  wire              clk,
  input  wire [3:0]        pwm,
  input  wire              clr,
  output logic [3:0][15:0] on_cnt
);
  // ----------
  // on-time counters
  // ----------
  // no break input here: the driver takes the outputs as always enabled
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (clr) on_cnt[k] <= 16'h0000;
      else on_cnt[k] <= on_cnt[k] + {15'h0000, pwm[k]};
    end
  end
endmodule // tpw_gate_model

/* tpw_core_tb.sv */
// self-checking testbench for the pwm timer core
`timescale 1ns/1ps
`include "tpw_map.vh"
module tpw_core_tb;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             reg_we = 1'b0;
  logic             reg_re = 1'b0;
  logic             realign = 1'b0;
  logic             clr = 1'b1;
  logic [3:0]       reg_addr = 4'h0;
  logic [15:0]      reg_wdata = 16'h0000;
  logic [15:0]      rdata;
  logic [3:0]       pwm_out;
  logic [3:0]       mflag;
  logic             upd;
  logic [3:0][15:0] on_cnt;
  int               errors = 0;
  int               compares = 0;
  // ----------
  // instances and clock
  // ----------
  tpw_core i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata_q(rdata), .counter_realign(realign), .pwm_out_q(pwm_out),
    .channel_match_flag_q(mflag), .update_flag_q(upd)
  );
  tpw_gate_model i_gate (.clk(clk), .pwm(pwm_out), .clr(clr), .on_cnt(on_cnt));
  initial forever #2 clk = ~clk;
  // ----------
  // shared tasks
  // ----------
  task automatic report_and_stop();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string w);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk16(rdata & m, e, w);
    @(posedge clk);
  endtask
  task automatic sync();
    realign <= 1'b1;
    @(posedge clk);
    realign <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_upd(output int t);
    t = 0;
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (upd !== 1'b1 && t < 200);
    if (t >= 200) begin
      errors++;
      $display("mismatch at %0t: no update flag", $time);
      report_and_stop();
    end
  endtask
  task automatic measure(input logic [15:0] e, input string w);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    for (int k = 0; k < 4; k++) chk16(on_cnt[k], e, w);
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_regs();
    rdchk(`TPW_A_CTRL, 16'hffff, `TPW_CTRL_RST, "ctrl reset");
    rdchk(`TPW_A_PERIOD, 16'hffff, `TPW_RST_PERIOD, "period reset");
    rdchk(`TPW_A_FLAG_EN, 16'hffff, 16'h0000, "flag enable reset");
    wr(4'he, 16'h1234);
    rdchk(4'he, 16'hffff, 16'h0000, "unmapped read");
    wr(`TPW_A_FLAG_EN, 16'h001f);
    rdchk(`TPW_A_FLAG_EN, 16'hffff, 16'h001f, "flag enable rw");
    $display("t_regs done");
  endtask
  task automatic t_init();
    // counter keeps running, one tick a clock: the read after realign sees one tick past zero
    wr(`TPW_A_CTRL, 16'h0081);
    wr(`TPW_A_INIT, 16'h0003);
    rdchk(`TPW_A_COUNT, 16'hffff, 16'h0003, "initial count");
    sync();
    rdchk(`TPW_A_COUNT, 16'hffff, 16'h0001, "realign count");
    wr(`TPW_A_CTRL, 16'h10e1);
    wr(`TPW_A_INIT, 16'h0002);
    rdchk(`TPW_A_STATE, 16'h0010, 16'h0010, "initial direction");
    $display("t_init done");
  endtask
  task automatic t_edge();
    int t;
    wr(`TPW_A_PRESC, 16'h0001);
    wr(`TPW_A_PERIOD, 16'h0004);
    wr(`TPW_A_CTRL, 16'h0081);
    sync();
    wait_upd(t);
    wait_upd(t);
    chk16(t[15:0], 16'h000a, "up period");
    rdchk(`TPW_A_COUNT, 16'hffff, 16'h0000, "up wrap");
    wr(`TPW_A_PERIOD, 16'h0006);
    wait_upd(t);
    chk16(t[15:0], 16'h0006, "period preload");
    wait_upd(t);
    chk16(t[15:0], 16'h000e, "new period");
    wr(`TPW_A_PERIOD, 16'h0004);
    wr(`TPW_A_CTRL, 16'h0091);
    wait_upd(t);
    wait_upd(t);
    chk16(t[15:0], 16'h000a, "down period");
    rdchk(`TPW_A_COUNT, 16'hffff, 16'h0004, "down reload");
    $display("t_edge done");
  endtask
  task automatic t_center();
    logic [15:0] ctl[5] = '{16'h0081, 16'h00a1, 16'h00c1, 16'h00e1, 16'h00e1};
    logic [15:0] fen[5] = '{16'h001f, 16'h001f, 16'h001f, 16'h0003, 16'h0001};
    logic [15:0] exp[5] = '{16'h0008, 16'h0008, 16'h0008, 16'h0004, 16'h0000};
    int          t;
    logic [15:0] c;
    for (int k = 4; k < 8; k++) wr(k[3:0], 16'h0002);
    for (int i = 0; i < 5; i++) begin
      wr(`TPW_A_FLAG_EN, fen[i]);
      wr(`TPW_A_CTRL, ctl[i]);
      sync();
      wait_upd(t);
      wait_upd(t);
      chk16(t[15:0], (i == 0) ? 16'h000a : 16'h0008, "update spacing");
      c = 16'h0000;
      repeat ((i == 0) ? 20 : 32) begin
        @(posedge clk);
        #1;
        c = c + mflag[0] + mflag[1] + mflag[2] + mflag[3];
      end
      chk16(c, exp[i], "match count");
    end
    $display("t_center done");
  endtask
  task automatic t_modes();
    logic [2:0]  md[8] = '{3'h4, 3'h1, 3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [15:0] hi[8] = '{16'h0000, 16'h0014, 16'h0014, 16'h0000, 16'h000a, 16'h0014, 16'h0008, 16'h000c};
    int          t;
    wr(`TPW_A_CTRL, 16'h0081);
    wr(`TPW_A_OSC, 16'h1111);
    for (int i = 0; i < 8; i++) begin
      wr(`TPW_A_MODE, {4'h0, md[i], md[i], md[i], md[i]});
      wait_upd(t);
      wait_upd(t);
      measure(hi[i], "mode on-time");
    end
    wr(`TPW_A_OSC, 16'h3333);
    measure(16'h0008, "inverted on-time");
    wr(`TPW_A_OSC, 16'h0000);
    measure(16'h0000, "disabled on-time");
    $display("t_modes done");
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_init();
    t_edge();
    t_center();
    t_modes();
    report_and_stop();
  end
endmodule // tpw_core_tb
